// *** hdl/appc_pkg.sv ***
// Package of register offsets, fields, reset values and timing constants
package appc_pkg;
  localparam int APPC_ADDR_W = 5;
  localparam logic [4:0] APPC_OFS_PULSE = 5'h1b;
  localparam logic [4:0] APPC_OFS_HEADING = 5'h1c;
  localparam int APPC_DATA_W = 24;
  // Pulse output control fields
  localparam int APPC_PO_ON = 23;
  localparam int APPC_PO_BAND_HI = 22;
  localparam int APPC_PO_BAND_LO = 20;
  localparam int APPC_PO_STEP_HI = 19;
  localparam int APPC_PO_STEP_LO = 16;
  localparam int APPC_PO_HYST = 14;
  localparam int APPC_PO_FREACT = 13;
  localparam int APPC_PO_FSTYLE = 12;
  localparam int APPC_PO_LINE = 3;
  localparam int APPC_PO_XCLK = 1;
  localparam int APPC_PO_CRC = 0;
  localparam logic [23:0] APPC_PO_RESET = 24'h670100;
  // Heading processing fields
  localparam int APPC_HD_AVG_HI = 23;
  localparam int APPC_HD_AVG_LO = 20;
  localparam int APPC_HD_FLIP = 19;
  localparam int APPC_HD_SENSE = 18;
  localparam int APPC_HD_HYS_HI = 17;
  localparam int APPC_HD_HYS_LO = 12;
  localparam int APPC_HD_OFS_HI = 11;
  localparam logic [23:0] APPC_HD_RESET = 24'h028000;
  localparam logic [3:0] APPC_AVG_MAX = 4'hc;
  localparam int APPC_ANGLE_W = 14;
  // Sample period and clock
  localparam int APPC_SAMPLE_NS = 1000;
  localparam int APPC_CLK_NS = 8;
  localparam int APPC_SAMPLE_CYC = APPC_SAMPLE_NS / APPC_CLK_NS;
  // Serial frame length that may carry one extra clock
  localparam logic [4:0] APPC_FRAME_BITS = 5'h10;
  // Carrier frequency table in Hz, index band*16+step
  localparam int APPC_FREQ_W = 12;
  localparam logic [11:0] APPC_FREQ_TAB [128] = '{
    12'd3125, 12'd3101, 12'd3077, 12'd3053, 12'd3030, 12'd3008, 12'd2985, 12'd2963,
    12'd2941, 12'd2920, 12'd2899, 12'd2878, 12'd2857, 12'd2837, 12'd2817, 12'd2797,
    12'd2778, 12'd2740, 12'd2703, 12'd2667, 12'd2632, 12'd2597, 12'd2564, 12'd2532,
    12'd2500, 12'd2469, 12'd2439, 12'd2410, 12'd2381, 12'd2353, 12'd2326, 12'd2299,
    12'd2273, 12'd2222, 12'd2174, 12'd2128, 12'd2083, 12'd2041, 12'd2000, 12'd1961,
    12'd1923, 12'd1887, 12'd1852, 12'd1818, 12'd1786, 12'd1754, 12'd1724, 12'd1695,
    12'd1667, 12'd1613, 12'd1563, 12'd1515, 12'd1471, 12'd1429, 12'd1389, 12'd1351,
    12'd1316, 12'd1282, 12'd1250, 12'd1220, 12'd1190, 12'd1163, 12'd1136, 12'd1111,
    12'd1087, 12'd1042, 12'd1000, 12'd962, 12'd926, 12'd893, 12'd862, 12'd833,
    12'd806, 12'd781, 12'd758, 12'd735, 12'd714, 12'd694, 12'd676, 12'd658,
    12'd641, 12'd610, 12'd581, 12'd556, 12'd532, 12'd510, 12'd490, 12'd472,
    12'd455, 12'd439, 12'd424, 12'd410, 12'd397, 12'd385, 12'd373, 12'd362,
    12'd352, 12'd333, 12'd316, 12'd301, 12'd287, 12'd275, 12'd263, 12'd253,
    12'd243, 12'd234, 12'd225, 12'd217, 12'd210, 12'd203, 12'd197, 12'd191,
    12'd185, 12'd175, 12'd166, 12'd157, 12'd150, 12'd143, 12'd137, 12'd131,
    12'd126, 12'd121, 12'd116, 12'd112, 12'd108, 12'd105, 12'd101, 12'd98
  };
endpackage

// *** hdl/appc_ang_if.sv ***
// Interface carrying averaged angle from the averager to the heading logic
`timescale 1ns/1ps
interface appc_ang_if;
  logic [13:0] angle;
  logic valid;
  logic [3:0] depth;
  modport src (output angle, output valid, input depth);
  modport dst (input angle, input valid, output depth);
endinterface

// *** hdl/appc_averager.sv ***
// Averager of one-microsecond angle samples in groups of a power of two
`timescale 1ns/1ps
module appc_averager
  import appc_pkg::*;
#(
  parameter int ANGLE_W = APPC_ANGLE_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw samples
  input wire logic [ANGLE_W-1:0] sample,
  input wire logic sample_stb,
  // Averaged result
  appc_ang_if.src out
);
  initial
  begin
    if (ANGLE_W != APPC_ANGLE_W) $error("appc_averager: angle width must be 14");
  end

  logic [25:0] acc_r;
  logic [12:0] cnt_r;
  logic [3:0] depth_c;
  logic [12:0] last_c;
  logic [25:0] sum_c;

  always_comb
  begin
    depth_c = (out.depth > APPC_AVG_MAX) ? APPC_AVG_MAX : out.depth; // [RQ11]
    last_c = 13'((14'h0001 << depth_c) - 14'h0001);
    sum_c = acc_r + 26'(sample);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc_r <= '0;
      cnt_r <= '0;
      out.valid <= 1'b0;
      out.angle <= '0;
    end
    else
    begin
      out.valid <= 1'b0;
      if (sample_stb)
      begin
        if (cnt_r >= last_c) // [RQ10]
        begin
          out.angle <= 14'(sum_c >> depth_c);
          out.valid <= 1'b1;
          acc_r <= '0;
          cnt_r <= '0;
        end
        else
        begin
          acc_r <= sum_c;
          cnt_r <= cnt_r + 13'h0001;
        end
      end
    end
  end

  avg_group_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sample_stb && depth_c == 4'h0) |=> out.valid) // [RQ10]
    else $error("depth zero must emit each sample");
  avg_clamp_a: assert property (@(posedge clk) disable iff (!rst_n)
    depth_c <= APPC_AVG_MAX) // [RQ11]
    else $error("averaging depth above twelve");
endmodule

// *** hdl/appc_top.sv ***
// Pulse output and angle post-processing configuration block
//
// Contract
// [RQ1] Enable bit drives or releases pulse pin
// [RQ2] Band and step select carrier table
// [RQ3] Hysteresis bit gates pulse value hysteresis
// [RQ4] Fault react bit makes output see errors
// [RQ5] Style zero releases pin on errors
// [RQ6] Style one halves carrier, codes duty
// [RQ7] CRC bit chooses checking and discard
// [RQ8] Line command ignore bit drops commands
// [RQ9] Extra clock bit ignores seventeenth edge
// [RQ10] Average two-power samples, one update each
// [RQ11] Averaging depth clamps at twelve
// [RQ12] Host should keep averaging at zero
// [RQ13] Flip bit adds half turn last
// [RQ14] Sense bit reverses direction after offset
// [RQ15] Six-bit angle hysteresis in 14-bit steps
// [RQ16] Subtract 12-bit offset before direction
// [RQ17] All angle arithmetic wraps modulo revolution; the averager sums and divides raw samples without wrap
// [RQ18] Carrier and errors only while enabled
`timescale 1ns/1ps
module appc_top
  import appc_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port
  input wire logic [4:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [23:0] REG_WDATA,
  output logic [23:0] REG_RDATA,
  // Measured angle samples
  input wire logic [13:0] RAW_ANGLE,
  input wire logic RAW_STB,
  // Error state and fault duty code
  input wire logic FAULT_ANY,
  input wire logic [11:0] FAULT_DUTY,
  // Serial packet checks
  input wire logic PKT_DONE,
  input wire logic PKT_CRC_OK,
  input wire logic [4:0] SER_EDGE_CNT,
  input wire logic SER_EDGE,
  // Supply line commands
  input wire logic LINE_CMD_STB,
  // Outputs
  output logic PULSE_OUT,
  output logic PULSE_OE,
  output logic [11:0] CARRIER_HZ,
  output logic [13:0] ANGLE_OUT,
  output logic ANGLE_VALID,
  output logic PKT_ACCEPT,
  output logic PKT_DISCARD,
  output logic LINE_CMD_TAKE,
  output logic SER_EDGE_TAKE
);
  typedef enum logic [2:0]
  {
    APPC_OFF = 3'b001,
    APPC_RUN = 3'b010,
    APPC_FLT = 3'b100
  } appc_mode_e;

  logic [23:0] pulse_output_control_r;
  logic [23:0] heading_processing_control_r;
  appc_mode_e mode_r;
  appc_mode_e mode_nxt;
  logic [11:0] period_r;
  logic [11:0] phase_r;
  logic [11:0] duty_r;
  logic [11:0] duty_nxt;
  logic [13:0] held_r;
  logic [13:0] proc_c;
  logic [13:0] hyst_c;
  logic [13:0] diff_c;
  logic [13:0] gap_c;
  logic [6:0] tab_idx_c;
  logic pulse_out_on;
  logic pulse_hyst_on;
  logic pulse_fault_react;
  logic fault_signal_style;
  logic crc_check_skip;
  logic line_cmd_ignore;
  logic extra_clock_ignore;
  logic [3:0] average_depth_exp;
  logic turn_sense_select;
  logic half_turn_flip;
  logic [5:0] hyst_steps;
  logic [11:0] zero_offset;
  logic [7:0] us_cnt_r;
  logic us_tick_r;
  logic [13:0] samp_r;

  appc_ang_if avg_if ();

  assign pulse_out_on = pulse_output_control_r[APPC_PO_ON];
  assign pulse_hyst_on = pulse_output_control_r[APPC_PO_HYST];
  assign pulse_fault_react = pulse_output_control_r[APPC_PO_FREACT];
  assign fault_signal_style = pulse_output_control_r[APPC_PO_FSTYLE];
  assign crc_check_skip = pulse_output_control_r[APPC_PO_CRC];
  assign line_cmd_ignore = pulse_output_control_r[APPC_PO_LINE];
  assign extra_clock_ignore = pulse_output_control_r[APPC_PO_XCLK];
  assign average_depth_exp = heading_processing_control_r[APPC_HD_AVG_HI:APPC_HD_AVG_LO];
  assign turn_sense_select = heading_processing_control_r[APPC_HD_SENSE];
  assign half_turn_flip = heading_processing_control_r[APPC_HD_FLIP];
  assign hyst_steps = heading_processing_control_r[APPC_HD_HYS_HI:APPC_HD_HYS_LO];
  assign zero_offset = heading_processing_control_r[APPC_HD_OFS_HI:0];
  assign avg_if.depth = average_depth_exp;

  // Register writes
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      pulse_output_control_r <= APPC_PO_RESET;
      heading_processing_control_r <= APPC_HD_RESET;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == APPC_OFS_PULSE)
        pulse_output_control_r <= REG_WDATA;
      if (REG_ADDR == APPC_OFS_HEADING)
        heading_processing_control_r <= REG_WDATA;
    end
  end

  // Register reads
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      REG_RDATA <= '0;
    else
    begin
      case (REG_ADDR)
        APPC_OFS_PULSE: REG_RDATA <= pulse_output_control_r;
        APPC_OFS_HEADING: REG_RDATA <= heading_processing_control_r;
        default: REG_RDATA <= '0;
      endcase
    end
  end

  // Microsecond sample pacing
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      us_cnt_r <= '0;
      us_tick_r <= 1'b0;
      samp_r <= '0;
    end
    else
    begin
      if (RAW_STB)
        samp_r <= RAW_ANGLE;
      us_tick_r <= (us_cnt_r == 8'(APPC_SAMPLE_CYC - 1));
      if (us_cnt_r == 8'(APPC_SAMPLE_CYC - 1))
        us_cnt_r <= '0;
      else
        us_cnt_r <= us_cnt_r + 8'h01;
    end
  end

  appc_averager #(.ANGLE_W(APPC_ANGLE_W)) u_avg (
    .clk(CLOCK),
    .rst_n(RST_N),
    .sample(samp_r),
    .sample_stb(us_tick_r),
    .out(avg_if.src)
  );

  // Offset, direction, half-turn, all modulo one turn
  always_comb
  begin
    proc_c = avg_if.angle - {zero_offset, 2'b00}; // [RQ16] [RQ17]
    if (turn_sense_select)
      proc_c = 14'h0000 - proc_c; // [RQ14]
    if (half_turn_flip)
      proc_c = proc_c + 14'h2000; // [RQ13]
    diff_c = proc_c - held_r;
    gap_c = diff_c[13] ? (14'h0000 - diff_c) : diff_c;
    hyst_c = (gap_c > 14'(hyst_steps)) ? proc_c : held_r; // [RQ15]
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      held_r <= '0;
      ANGLE_OUT <= '0;
      ANGLE_VALID <= 1'b0;
    end
    else
    begin
      ANGLE_VALID <= avg_if.valid;
      if (avg_if.valid)
      begin
        held_r <= hyst_c;
        ANGLE_OUT <= hyst_c; // [RQ15]
      end
    end
  end

  // Pulse mode selection
  always_comb
  begin
    mode_nxt = APPC_RUN;
    if (!pulse_out_on)
      mode_nxt = APPC_OFF; // [RQ1] [RQ18]
    else if (pulse_fault_react && FAULT_ANY) // [RQ4]
      mode_nxt = APPC_FLT;
    tab_idx_c = {pulse_output_control_r[APPC_PO_BAND_HI:APPC_PO_BAND_LO],
                 pulse_output_control_r[APPC_PO_STEP_HI:APPC_PO_STEP_LO]}; // [RQ2]
    duty_nxt = pulse_hyst_on ? held_r[13:2] : proc_c[13:2]; // [RQ3]
    if (mode_nxt == APPC_FLT && fault_signal_style)
      duty_nxt = FAULT_DUTY; // [RQ6]
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      mode_r <= APPC_OFF;
    else
      mode_r <= mode_nxt;
  end

  // Carrier and duty generation
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      period_r <= '0;
      phase_r <= '0;
      duty_r <= '0;
      CARRIER_HZ <= '0;
      PULSE_OUT <= 1'b0;
      PULSE_OE <= 1'b0;
    end
    else
    begin
      case (mode_nxt)
        APPC_OFF:
        begin
          CARRIER_HZ <= '0;
          PULSE_OE <= 1'b0; // [RQ1] [RQ18]
          PULSE_OUT <= 1'b0;
        end
        APPC_RUN:
        begin
          CARRIER_HZ <= APPC_FREQ_TAB[tab_idx_c]; // [RQ2]
          PULSE_OE <= 1'b1; // [RQ1]
          PULSE_OUT <= (phase_r < duty_r);
        end
        APPC_FLT:
        begin
          CARRIER_HZ <= APPC_FREQ_TAB[tab_idx_c] >> 1; // [RQ6]
          PULSE_OE <= fault_signal_style; // [RQ5]
          PULSE_OUT <= fault_signal_style && (phase_r < duty_r);
        end
        default:
        begin
          CARRIER_HZ <= '0;
          PULSE_OE <= 1'b0;
          PULSE_OUT <= 1'b0;
        end
      endcase
      period_r <= 12'hfff;
      if (phase_r == period_r)
      begin
        phase_r <= '0;
        duty_r <= duty_nxt;
      end
      else
        phase_r <= phase_r + 12'h001;
    end
  end

  // Serial and line command filtering
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      PKT_ACCEPT <= 1'b0;
      PKT_DISCARD <= 1'b0;
      LINE_CMD_TAKE <= 1'b0;
      SER_EDGE_TAKE <= 1'b0;
    end
    else
    begin
      PKT_ACCEPT <= PKT_DONE && (crc_check_skip ? 1'b1 : PKT_CRC_OK); // [RQ7]
      PKT_DISCARD <= PKT_DONE && !crc_check_skip && !PKT_CRC_OK; // [RQ7]
      LINE_CMD_TAKE <= LINE_CMD_STB && !line_cmd_ignore; // [RQ8]
      SER_EDGE_TAKE <= SER_EDGE && !(extra_clock_ignore && SER_EDGE_CNT == APPC_FRAME_BITS); // [RQ9]
    end
  end

  pin_off_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !pulse_out_on |=> !PULSE_OE) // [RQ1]
    else $error("pulse pin driven while disabled");
  fault_tristate_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (pulse_out_on && pulse_fault_react && !fault_signal_style && FAULT_ANY) |=> !PULSE_OE) // [RQ5]
    else $error("pin not released on fault");
  fault_halve_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (pulse_out_on && pulse_fault_react && fault_signal_style && FAULT_ANY)
    |=> CARRIER_HZ == ($past(APPC_FREQ_TAB[tab_idx_c]) >> 1)) // [RQ6]
    else $error("carrier not halved on fault");
  no_react_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (pulse_out_on && !pulse_fault_react) |=> PULSE_OE) // [RQ4]
    else $error("output reacted to fault while disabled");
  carrier_tab_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (pulse_out_on && !FAULT_ANY && tab_idx_c == 7'h00) |=> CARRIER_HZ == 12'd3125) // [RQ2]
    else $error("carrier table entry wrong");
  crc_drop_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (PKT_DONE && !crc_check_skip && !PKT_CRC_OK) |=> PKT_DISCARD && !PKT_ACCEPT) // [RQ7]
    else $error("bad packet not discarded");
  line_ign_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (LINE_CMD_STB && line_cmd_ignore) |=> !LINE_CMD_TAKE) // [RQ8]
    else $error("line command taken while ignored");
  edge17_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (SER_EDGE && extra_clock_ignore && SER_EDGE_CNT == APPC_FRAME_BITS) |=> !SER_EDGE_TAKE) // [RQ9]
    else $error("extra clock edge not ignored");
  flip_last_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (avg_if.valid && hyst_steps == 6'h00 && !turn_sense_select && half_turn_flip)
    |=> ANGLE_OUT == 14'($past(avg_if.angle) - {$past(zero_offset), 2'b00} + 14'h2000)) // [RQ13] [RQ16]
    else $error("offset or half turn wrong");
  sense_rev_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (avg_if.valid && hyst_steps == 6'h00 && turn_sense_select && !half_turn_flip)
    |=> ANGLE_OUT == 14'(14'h0000 - ($past(avg_if.angle) - {$past(zero_offset), 2'b00}))) // [RQ14] [RQ17]
    else $error("direction reversal wrong");
  hyst_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (avg_if.valid && gap_c <= 14'(hyst_steps)) |=> held_r == $past(held_r)) // [RQ15]
    else $error("hysteresis let small step through");
  pulse_hyst_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (phase_r == period_r && !(pulse_out_on && pulse_fault_react && FAULT_ANY) && pulse_hyst_on)
    |=> duty_r == $past(held_r[13:2])) // [RQ3]
    else $error("pulse hysteresis source wrong");
  mode_hot_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $onehot(mode_r)) // [RQ1]
    else $error("pulse mode not one-hot");
endmodule

// *** dv/appc_host_model.sv ***
// Host model that clocks serial frames into the block and counts taken edges
`timescale 1ns/1ps
module appc_host_model
  import appc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Frame request and result
  input wire logic frame_go,
  output logic frame_done,
  output logic [4:0] taken,
  // Serial edges toward the block
  output logic ser_edge,
  output logic [4:0] ser_cnt,
  input wire logic edge_take
);
  logic [6:0] tick_r;
  logic busy_r;
  // Seventeen edges a frame, four cycles apart, index 0 to 16
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tick_r <= 7'h00;
      busy_r <= 1'b0;
      ser_edge <= 1'b0;
      ser_cnt <= 5'h1f;
      frame_done <= 1'b0;
      taken <= 5'h00;
    end
    else if (frame_go && !busy_r)
    begin
      busy_r <= 1'b1;
      tick_r <= 7'h00;
      taken <= 5'h00;
      frame_done <= 1'b0;
    end
    else if (busy_r)
    begin
      tick_r <= tick_r + 7'h01;
      ser_edge <= (tick_r[1:0] == 2'b00) && (tick_r[6:2] <= APPC_FRAME_BITS);
      if (tick_r[1:0] == 2'b00)
        ser_cnt <= tick_r[6:2];
      taken <= taken + {4'h0, edge_take};
      if (tick_r == 7'h48)
      begin
        busy_r <= 1'b0;
        frame_done <= 1'b1;
        ser_cnt <= ~ser_cnt;
      end
    end
  end
endmodule

// *** dv/angle_postproc_pwm_config_bench.sv ***
// Self-checking bench of the pulse and heading configuration block
`timescale 1ns/1ps
module angle_postproc_pwm_config_bench;
  import appc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr = 1'b0;
  logic [23:0] reg_wdata = 24'h000000;
  logic [13:0] raw_angle = 14'h0000;
  logic raw_stb = 1'b1;
  logic fault_any = 1'b0;
  logic [11:0] fault_duty = 12'h123;
  logic pkt_done = 1'b0;
  logic pkt_crc_ok = 1'b0;
  logic line_cmd_stb = 1'b0;
  logic frame_go = 1'b0;
  logic [23:0] reg_rdata;
  logic [11:0] carrier_hz;
  logic [13:0] angle_out;
  logic [4:0] ser_edge_cnt, taken;
  logic ser_edge, frame_done, pulse_out, pulse_oe, angle_valid;
  logic pkt_accept, pkt_discard, line_cmd_take, ser_edge_take;
  int failures = 0;
  int n_tests = 0;

  appc_top dut (.CLOCK(clock), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .RAW_ANGLE(raw_angle), .RAW_STB(raw_stb),
    .FAULT_ANY(fault_any), .FAULT_DUTY(fault_duty), .PKT_DONE(pkt_done),
    .PKT_CRC_OK(pkt_crc_ok), .SER_EDGE_CNT(ser_edge_cnt), .SER_EDGE(ser_edge),
    .LINE_CMD_STB(line_cmd_stb), .PULSE_OUT(pulse_out), .PULSE_OE(pulse_oe),
    .CARRIER_HZ(carrier_hz), .ANGLE_OUT(angle_out), .ANGLE_VALID(angle_valid),
    .PKT_ACCEPT(pkt_accept), .PKT_DISCARD(pkt_discard), .LINE_CMD_TAKE(line_cmd_take),
    .SER_EDGE_TAKE(ser_edge_take));

  appc_host_model host (.clk(clock), .rst_n(rst_n), .frame_go(frame_go),
    .frame_done(frame_done), .taken(taken), .ser_edge(ser_edge), .ser_cnt(ser_edge_cnt),
    .edge_take(ser_edge_take));

  initial
  begin
    forever #4 clock = ~clock;
  end

  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [23:0] g, input logic [23:0] e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic timeout;
    failures++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    stop_test();
  endtask

  function automatic logic [23:0] pw(input logic on, input logic [2:0] b,
    input logic [3:0] s, input logic [2:0] fl, input logic [3:0] lo);
    return {on, b, s, 1'b0, fl, 8'h00, lo};
  endfunction

  function automatic logic [23:0] hd(input logic [3:0] av, input logic fl, input logic se,
    input logic [5:0] hy, input logic [11:0] of);
    return {av, fl, se, hy, of};
  endfunction

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [23:0] e);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    #1;
    check(reg_rdata, e);
  endtask

  task automatic setpo(input logic [23:0] d);
    wr(APPC_OFS_PULSE, d);
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic wait_valid(output int n);
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end
    while (angle_valid !== 1'b1 && n < 20000);
    if (n >= 20000)
      timeout();
  endtask

  task automatic ang(input logic [13:0] raw, input logic [23:0] h, input logic [13:0] e);
    int n;
    wr(APPC_OFS_HEADING, h);
    raw_angle <= raw;
    wait_valid(n);
    wait_valid(n);
    check(angle_out, e);
  endtask

  task automatic rate(input logic [3:0] d);
    int n;
    wr(APPC_OFS_HEADING, hd(d, 1'b0, 1'b0, 6'h00, 12'h000));
    wait_valid(n);
    wait_valid(n);
    wait_valid(n);
    check(24'(n), 24'(125 << d));
  endtask

  task automatic duty(input logic [23:0] e);
    int h;
    h = 0;
    repeat (4096) @(posedge clock);
    repeat (4096)
    begin
      @(posedge clock);
      #1;
      if (pulse_out === 1'b1)
        h++;
    end
    check(24'(h), e);
  endtask

  task automatic fire(input logic pkt, input logic ok);
    @(posedge clock);
    pkt_done <= pkt;
    pkt_crc_ok <= ok;
    line_cmd_stb <= !pkt;
    @(posedge clock);
    pkt_done <= 1'b0;
    line_cmd_stb <= 1'b0;
    #1;
  endtask

  task automatic frame(input logic [23:0] e);
    int k;
    @(posedge clock);
    frame_go <= 1'b1;
    @(posedge clock);
    frame_go <= 1'b0;
    #1;
    k = 0;
    while (frame_done !== 1'b1 && k < 200)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k >= 200)
      timeout();
    check(taken, e);
  endtask

  initial
  begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    check(pulse_oe, 1'b0);
    rd(APPC_OFS_PULSE, 24'h670100);
    rd(APPC_OFS_HEADING, 24'h028000);
    rd(5'h1a, 24'h000000);
    wr(5'h1d, 24'hffffff);
    rd(5'h1d, 24'h000000);
    rd(APPC_OFS_PULSE, 24'h670100);
    wr(APPC_OFS_PULSE, 24'hf7700b);
    rd(APPC_OFS_PULSE, 24'hf7700b);
    wr(APPC_OFS_HEADING, 24'h5a5a5a);
    rd(APPC_OFS_HEADING, 24'h5a5a5a);
    for (int i = 0; i < 128; i++)
    begin
      setpo(pw(1'b1, i[6:4], i[3:0], 3'b000, 4'h0));
      check(carrier_hz, APPC_FREQ_TAB[i]);
      check(pulse_oe, 1'b1);
    end
    setpo(pw(1'b1, 3'h0, 4'h0, 3'b000, 4'h0));
    check(carrier_hz, 12'd3125);
    setpo(pw(1'b1, 3'h7, 4'hf, 3'b000, 4'h0));
    check(carrier_hz, 12'd98);
    @(posedge clock);
    fault_any <= 1'b1;
    setpo(pw(1'b1, 3'h1, 4'h8, 3'b000, 4'h0));
    check(pulse_oe, 1'b1);
    check(carrier_hz, 12'd2500);
    setpo(pw(1'b1, 3'h1, 4'h8, 3'b010, 4'h0));
    check(pulse_oe, 1'b0);
    setpo(pw(1'b1, 3'h1, 4'h8, 3'b011, 4'h0));
    check(pulse_oe, 1'b1);
    check(carrier_hz, 12'd1250);
    duty(24'd291);
    setpo(pw(1'b0, 3'h1, 4'h8, 3'b011, 4'h0));
    check(pulse_oe, 1'b0);
    check(carrier_hz, 12'd0);
    @(posedge clock);
    fault_any <= 1'b0;
    ang(14'h0010, hd(4'h0, 1'b0, 1'b0, 6'h00, 12'h008), 14'h3ff0);
    ang(14'h0100, hd(4'h0, 1'b0, 1'b1, 6'h00, 12'h000), 14'h3f00);
    ang(14'h1000, hd(4'h0, 1'b1, 1'b1, 6'h00, 12'h100), 14'h1400);
    ang(14'h1000, hd(4'h0, 1'b0, 1'b0, 6'h00, 12'h000), 14'h1000);
    setpo(pw(1'b1, 3'h1, 4'h8, 3'b000, 4'h0));
    duty(24'd1024);
    ang(14'h1028, hd(4'h0, 1'b0, 1'b0, 6'h28, 12'h000), 14'h1000);
    setpo(pw(1'b1, 3'h1, 4'h8, 3'b100, 4'h0));
    duty(24'd1024);
    ang(14'h1029, hd(4'h0, 1'b0, 1'b0, 6'h28, 12'h000), 14'h1029);
    rate(4'h3);
    rate(4'h0);
    fire(1'b1, 1'b0);
    check(pkt_discard, 1'b1);
    check(pkt_accept, 1'b0);
    fire(1'b1, 1'b1);
    check(pkt_accept, 1'b1);
    setpo(pw(1'b1, 3'h1, 4'h8, 3'b000, 4'h1));
    fire(1'b1, 1'b0);
    check(pkt_accept, 1'b1);
    check(pkt_discard, 1'b0);
    fire(1'b0, 1'b0);
    check(line_cmd_take, 1'b1);
    setpo(pw(1'b1, 3'h1, 4'h8, 3'b000, 4'h8));
    fire(1'b0, 1'b0);
    check(line_cmd_take, 1'b0);
    setpo(pw(1'b1, 3'h1, 4'h8, 3'b000, 4'h2));
    frame(24'd16);
    setpo(pw(1'b1, 3'h1, 4'h8, 3'b000, 4'h0));
    frame(24'd17);
    stop_test();
  end
endmodule
